// ==== rtl/fwp_pkg.sv ====
// Contract
// - Complement mode: protect bits 000 all, 111 none
// - Small-region complement leaves one top/bottom hole
// - Erase/program touching protection is ignored
// - Lock bits used only when scheme select 1
// - All lock bits set at power-up
// - Chip select fall starts new instruction
// - First byte after select is opcode
// - Sample rising clock edge, MSB first
// - Opcode followed by address, data, dummy bytes
// - Chip select rise completes instruction
// - Reads may end after any bit; the code still discards any frame shorter than 8 bits
// - Writes need whole bytes else discarded
// - Busy: only read-status accepted
// - Scheme 0: protection from protect bits
// - Lock bits set again on reset
`default_nettype none
package fwp_pkg;
    localparam int ADDR_W = 23;
    localparam int NUM_BLOCKS = 128;
    localparam int BLK_SHIFT = 16;
    localparam logic [2:0] PROT_NONE = 3'h0;
    localparam logic [2:0] PROT_ALL = 3'h7;
    localparam logic LOCK_RESET = 1'h1;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic complement_protect;
        logic protect_scheme_select;
        logic small_region_select;
        logic top_bottom_select;
        logic [2:0] block_protect_bits;
    } fwp_prot_cfg_type;

    typedef struct packed {
        logic [7:0] opcode;
        logic [31:0] tail;
        logic [5:0] bits;
        logic byte_aligned;
    } fwp_frame_type;
endpackage : fwp_pkg
`default_nettype wire

// ==== rtl/fwp_prot_decode.sv ====
`default_nettype none
module fwp_prot_decode (
    // Config
    input wire fwp_pkg::fwp_prot_cfg_type cfg_in,
    input wire logic [fwp_pkg::NUM_BLOCKS-1:0] lock_in,
    // Target range
    input wire logic [fwp_pkg::ADDR_W-1:0] lo_in,
    input wire logic [fwp_pkg::ADDR_W-1:0] hi_in,
    // Result
    output logic hit_out
);
    logic [fwp_pkg::ADDR_W:0] plo;
    logic [fwp_pkg::ADDR_W:0] phi;
    logic none;
    logic lock_hit;
    logic [2:0] pbits;
    always_comb begin
        pbits = cfg_in.block_protect_bits;
        none = 1'b0;
        plo = '0;
        phi = '0;
        if (pbits == fwp_pkg::PROT_NONE) begin
            none = 1'b1;
        end else if (pbits == fwp_pkg::PROT_ALL) begin
            phi = 24'h800000;
        end else if (cfg_in.small_region_select) begin
            // 4KB region doubles per step, 32KB caps it
            phi = 24'h001000 << (pbits[2] ? 3'h3 : {1'b0, pbits[1:0]} - 3'h1);
        end else begin
            phi = 24'h010000 << pbits;
        end
        if (!none && !cfg_in.top_bottom_select) begin
            plo = 24'h800000 - phi;
            phi = 24'h800000;
        end
        if (cfg_in.complement_protect) begin
            if (none) begin
                none = 1'b0;
                plo = '0;
                phi = 24'h800000;
            end else if (plo == '0 && phi == 24'h800000) begin
                none = 1'b1;
            end else if (plo == '0) begin
                plo = phi;
                phi = 24'h800000;
            end else begin
                phi = plo;
                plo = '0;
            end
        end
    end
    always_comb begin
        lock_hit = 1'b0;
        for (int i = 0; i < fwp_pkg::NUM_BLOCKS; i++) begin
            if (lock_in[i] && i >= int'(lo_in >> fwp_pkg::BLK_SHIFT)
                && i <= int'(hi_in >> fwp_pkg::BLK_SHIFT)) begin
                lock_hit = 1'b1;
            end
        end
    end
    assign hit_out = cfg_in.protect_scheme_select ? lock_hit :
        (!none && ({1'b0, lo_in} < phi) && ({1'b0, hi_in} >= plo));
endmodule : fwp_prot_decode
`default_nettype wire

// ==== rtl/fwp_top.sv ====
`default_nettype none
module fwp_top (
    // Clock, reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    // SPI pins
    input wire logic cs_b_in,
    input wire logic sclk_in,
    input wire logic serial_in,
    // Protect config
    input wire fwp_pkg::fwp_prot_cfg_type cfg_in,
    // Device state
    input wire logic busy_in,
    input wire logic is_read_op_in,
    input wire logic is_write_op_in,
    input wire logic is_range_op_in,
    input wire logic [fwp_pkg::ADDR_W-1:0] range_size_in,
    input wire logic lock_set_in,
    input wire logic lock_clr_in,
    input wire logic lock_all_in,
    input wire logic unlock_all_in,
    // Results
    output logic start_out,
    output logic opcode_valid_out,
    output logic [7:0] opcode_out,
    output logic exec_out,
    output logic [31:0] frame_tail_out,
    output logic discard_out,
    output logic [fwp_pkg::NUM_BLOCKS-1:0] lock_out
);
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] ck_s;
        logic [1:0] sin_s;
        logic active;
        fwp_pkg::fwp_frame_type fr;
        logic start;
        logic opv;
        logic exec;
        logic discard;
        logic [fwp_pkg::NUM_BLOCKS-1:0] lock;
    } fwp_state_type;

    fwp_state_type st;
    fwp_state_type next_st;
    logic prot_hit;
    logic [fwp_pkg::ADDR_W-1:0] tgt_lo;
    logic [fwp_pkg::ADDR_W-1:0] tgt_hi;
    logic cs_fall;
    logic cs_rise;
    logic ck_rise;
    logic [7:0] cur_op;
    logic [31:0] shifted;

    assign tgt_lo = st.fr.tail[fwp_pkg::ADDR_W-1:0];
    assign tgt_hi = tgt_lo | (range_size_in - 23'h000001);

    fwp_prot_decode u_dec (
        .cfg_in(cfg_in),
        .lock_in(st.lock),
        .lo_in(tgt_lo),
        .hi_in(tgt_hi),
        .hit_out(prot_hit)
    );

    // Only stages 1+ are read: stage 0 is the metastable flop
    assign cs_fall = st.cs_s[2] && !st.cs_s[1];
    assign cs_rise = !st.cs_s[2] && st.cs_s[1];
    assign ck_rise = !st.ck_s[2] && st.ck_s[1];
    assign cur_op = st.fr.opcode;
    assign shifted = {st.fr.tail[30:0], st.sin_s[1]};

    always_comb begin
        next_st = st;
        next_st.cs_s = {st.cs_s[1:0], cs_b_in};
        next_st.ck_s = {st.ck_s[1:0], sclk_in};
        next_st.sin_s = {st.sin_s[0], serial_in};
        next_st.start = 1'b0;
        next_st.opv = 1'b0;
        next_st.exec = 1'b0;
        next_st.discard = 1'b0;
        if (cs_fall) begin
            next_st.active = 1'b1;
            next_st.fr = '0;
            next_st.fr.byte_aligned = 1'b1;
            next_st.start = 1'b1;
        end else if (st.active && !st.cs_s[1] && ck_rise) begin
            if (st.fr.bits < 6'h08) begin
                next_st.fr.opcode = {st.fr.opcode[6:0], st.sin_s[1]};
                if (st.fr.bits == 6'h07) begin
                    next_st.opv = 1'b1;
                end
            end else begin
                next_st.fr.tail = shifted;
            end
            // Long frames keep counting modulo 8 so alignment stays true
            if (st.fr.bits[5:3] != 3'h7) begin
                next_st.fr.bits = st.fr.bits + 6'h01;
            end else begin
                next_st.fr.bits[2:0] = st.fr.bits[2:0] + 3'h1;
            end
            next_st.fr.byte_aligned = (st.fr.bits[2:0] == 3'h7);
        end else if (st.active && cs_rise) begin
            next_st.active = 1'b0;
            if (st.fr.bits < 6'h08) begin
                next_st.discard = 1'b1;
            end else if (busy_in && cur_op != fwp_pkg::OP_READ_STATUS) begin
                next_st.discard = 1'b1;
            end else if (is_read_op_in) begin
                next_st.exec = 1'b1;
            end else if (is_write_op_in && !st.fr.byte_aligned) begin
                next_st.discard = 1'b1;
            end else if (is_range_op_in && prot_hit) begin
                next_st.discard = 1'b1;
            end else begin
                next_st.exec = 1'b1;
            end
        end
        // Lock updates from the command layer; lock-all wins, then unlock-all, then per-block set over clear
        if (lock_all_in) begin
            next_st.lock = {fwp_pkg::NUM_BLOCKS{1'b1}};
        end else if (unlock_all_in) begin
            next_st.lock = '0;
        end else begin
            for (int i = 0; i < fwp_pkg::NUM_BLOCKS; i++) begin
                if (lock_set_in && i == int'(tgt_lo >> fwp_pkg::BLK_SHIFT)) begin
                    next_st.lock[i] = 1'b1;
                end else if (lock_clr_in && i == int'(tgt_lo >> fwp_pkg::BLK_SHIFT)) begin
                    next_st.lock[i] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st <= '0;
            st.cs_s <= 3'h7;
            st.lock <= {fwp_pkg::NUM_BLOCKS{fwp_pkg::LOCK_RESET}};
        end else if (clk_en_in) begin
            st <= next_st;
        end
    end

    assign start_out = st.start;
    assign opcode_valid_out = st.opv;
    assign opcode_out = st.fr.opcode;
    assign exec_out = st.exec;
    assign frame_tail_out = st.fr.tail;
    assign discard_out = st.discard;
    assign lock_out = st.lock;
endmodule : fwp_top
`default_nettype wire

// ==== sim/fwp_props.sv ====
`default_nettype none
module fwp_props (
    // Clock, pins
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic cs_b_in,
    input wire fwp_pkg::fwp_prot_cfg_type cfg_in,
    input wire logic busy_in,
    input wire logic is_range_op_in,
    // Results
    input wire logic start_out,
    input wire logic opcode_valid_out,
    input wire logic [7:0] opcode_out,
    input wire logic exec_out,
    input wire logic discard_out,
    input wire logic [31:0] frame_tail_out,
    input wire logic [fwp_pkg::NUM_BLOCKS-1:0] lock_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    start_seen_a: assert property ($fell(cs_b_in) |-> ##[2:5] start_out)
        else $error("no start");
    end_seen_a: assert property ($rose(cs_b_in) |-> ##[2:5] (exec_out || discard_out))
        else $error("no result");
    one_result_a: assert property (!(exec_out && discard_out))
        else $error("both results");
    lock_reset_a: assert property (!$past(rst_b_in) |-> &lock_out)
        else $error("locks not set");
    busy_refuse_a: assert property ($rose(cs_b_in) && busy_in
        && opcode_out != fwp_pkg::OP_READ_STATUS
        |-> ##[2:5] discard_out)
        else $error("busy not refused");
    opcode_frame_a: assert property (opcode_valid_out |-> !cs_b_in)
        else $error("opcode outside frame");
    all_protect_a: assert property ($rose(cs_b_in) && is_range_op_in && cfg_in == 7'h40
        |-> ##[2:5] discard_out)
        else $error("protected erase run");
    lock_protect_a: assert property ($rose(cs_b_in) && is_range_op_in
        && cfg_in.protect_scheme_select && &lock_out |-> ##[2:5] discard_out)
        else $error("locked erase run");
    tail_hold_a: assert property (cs_b_in [*6] |-> $stable(frame_tail_out))
        else $error("tail moved");
endmodule : fwp_props
`default_nettype wire

// ==== sim/fwp_host.sv ====
`default_nettype none
module fwp_host (
    // SPI pins
    output logic cs_b_out,
    output logic sclk_out,
    output logic serial_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_b_out = 1'b1;
        sclk_out = 1'b0;
        serial_out = 1'b0;
    end
    // Clock idles low between frames
    task automatic frame(input logic [39:0] d, input int n);
        cs_b_out = 1'b0;
        #200;
        for (int i = 0; i < n; i++) begin
            serial_out = d[39 - i];
            #200 sclk_out = 1'b1;
            #200 sclk_out = 1'b0;
        end
        #200 cs_b_out = 1'b1;
        serial_out = ~serial_out;
    endtask : frame
endmodule : fwp_host
`default_nettype wire

// ==== sim/fwp_top_tb.sv ====
`default_nettype none
module fwp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b, sclk, sdi, st, ov, ex, dc;
    fwp_pkg::fwp_prot_cfg_type cfg = 7'h47;
    logic busy = 1'b0;
    logic lk_clr = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [22:0] size = 23'h001000;
    logic [7:0] op;
    logic [31:0] tail;
    logic [fwp_pkg::NUM_BLOCKS-1:0] lk;
    int bad_count = 0;
    int n_checks = 0;
    int n_st = 0;
    int n_ov = 0;
    always #25 clk = ~clk;
    // Pulses counted mid-cycle, where they are settled
    always @(negedge clk) begin
        if (st) n_st++;
        if (ov) n_ov++;
    end
    fwp_host host_u (.cs_b_out(cs_b), .sclk_out(sclk), .serial_out(sdi));
    fwp_top dut_u (.ref_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(1'b1), .cs_b_in(cs_b),
        .sclk_in(sclk), .serial_in(sdi), .cfg_in(cfg), .busy_in(busy),
        .is_read_op_in(kind[2]), .is_write_op_in(kind[1]), .is_range_op_in(kind[0]),
        .range_size_in(size), .lock_set_in(1'b0), .lock_clr_in(lk_clr), .lock_all_in(1'b0),
        .unlock_all_in(1'b0), .start_out(st), .opcode_valid_out(ov), .opcode_out(op),
        .exec_out(ex), .frame_tail_out(tail), .discard_out(dc), .lock_out(lk));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("checks=%0d bad=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    // Waits for the result pulse; a lost pulse ends the run
    task automatic run(input logic [2:0] k, input logic [39:0] d, input int n, input logic e);
        int i;
        int s0;
        int v0;
        kind = k;
        s0 = n_st;
        v0 = n_ov;
        host_u.frame(d, n);
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (ex || dc) break;
        end
        if (i == 20) begin
            bad_count++;
            stop_test();
        end
        check(ex, e);
        check(n_st - s0, 1);
        check(n_ov - v0, n >= 8);
        repeat (4) @(posedge clk);
        #1;
    endtask : run
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check(&lk, 1'b1);
        run(3'h4, {8'h05, 32'h0}, 8, 1'b1);
        check(op, 8'h05);
        run(3'h4, {8'h03, 32'h0}, 35, 1'b1);
        run(3'h4, {8'h05, 32'h0}, 5, 1'b0);
        run(3'h2, {8'h02, 32'h000100A5}, 35, 1'b0);
        run(3'h2, {8'h02, 32'h000100A5}, 40, 1'b1);
        check(tail, 32'h000100A5);
        busy = 1'b1;
        run(3'h0, {8'h06, 32'h0}, 8, 1'b0);
        run(3'h4, {8'h05, 32'h0}, 8, 1'b1);
        busy = 1'b0;
        $display("framing test done");
        run(3'h3, {8'h20, 32'h0}, 32, 1'b1);
        cfg = 7'h40;
        run(3'h3, {8'h20, 32'h0}, 32, 1'b0);
        cfg = 7'h59;
        run(3'h3, {8'h20, 32'h0}, 32, 1'b1);
        run(3'h3, {8'h20, 32'h00100000}, 32, 1'b0);
        size = 23'h002000;
        run(3'h3, {8'h52, 32'h0}, 32, 1'b0);
        size = 23'h001000;
        cfg = 7'h60;
        run(3'h3, {8'h20, 32'h0}, 32, 1'b0);
        lk_clr = 1'b1;
        @(posedge clk);
        #1 lk_clr = 1'b0;
        check(lk[0], 1'b0);
        run(3'h3, {8'h20, 32'h0}, 32, 1'b1);
        cfg = 7'h40;
        run(3'h3, {8'h20, 32'h0}, 32, 1'b0);
        rst_b = 1'b0;
        @(posedge clk);
        #1 rst_b = 1'b1;
        check(&lk, 1'b1);
        $display("protect test done");
        stop_test();
    end
    // Hang guard
    initial begin
        #1000000;
        bad_count++;
        stop_test();
    end
endmodule : fwp_top_tb
bind fwp_top fwp_props chk_u (.*);
`default_nettype wire
